// ---- rtl/gpr_pkg.sv ----
// Types shared by the pulse and report scheduler.
// Assumes nothing beyond the constants header.
package gpr_pkg;
    typedef enum logic [2:0] {
        GPR_IDLE = 3'h0,
        GPR_ID = 3'h1,
        GPR_BODY = 3'h3,
        GPR_ESC = 3'h2,
        GPR_TAIL1 = 3'h6,
        GPR_TAIL2 = 3'h7
    } gpr_fsm_e;

    typedef struct packed {
        logic [1:0] pos_fmt;
        logic vel_enu;
    } gpr_fmt_s;

    typedef struct packed {
        logic [7:0] ctl_port;
        logic [7:0] aux_port;
    } gpr_port_cfg_s;
endpackage : gpr_pkg

// ---- rtl/gpr_regs.svh ----
// Timing, framing and report constants of the pulse and report scheduler.
// Assumes a single 50 MHz reference clock.
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

`define GPR_CLK_HZ 50000000
`define GPR_CLK_NS 20
`define GPR_PULSE_NS 10000
`define GPR_PULSE_CYC ((`GPR_PULSE_NS + `GPR_CLK_NS - 1) / `GPR_CLK_NS)
`define GPR_STEER_HZ 3126000
`define GPR_STEER_CYC (`GPR_CLK_HZ / `GPR_STEER_HZ)
`define GPR_SLOW_EPOCHS 5

`define GPR_DLE 8'h10
`define GPR_ETX 8'h03

`define GPR_ID_TIME 8'h41
`define GPR_ID_HEALTH 8'h46
`define GPR_ID_STATUS 8'h4B
`define GPR_ID_POS_XYZ_S 8'h42
`define GPR_ID_POS_XYZ_D 8'h83
`define GPR_ID_POS_LLA_S 8'h4A
`define GPR_ID_POS_LLA_D 8'h84
`define GPR_ID_VEL_XYZ 8'h43
`define GPR_ID_VEL_ENU 8'h56
`define GPR_ID_SATSEL 8'h6D
`define GPR_ID_DIFFFIX 8'h82

`define GPR_P_TIME 0
`define GPR_P_HEALTH 1
`define GPR_P_STATUS 2
`define GPR_P_POS 3
`define GPR_P_VEL 4
`define GPR_P_SATSEL 5
`define GPR_P_DIFFFIX 6
`define GPR_P_HOST 7
`define GPR_NPEND 8

`endif

// ---- rtl/gpr_sched.sv ----
// Second timing pulse generator, periodic report scheduler and packet framer.
// Assumes payload bytes, navigation alignment and non-volatile storage come
// from logic on ref_clk; serial byte transmitter is downstream of tx_*.
// Function
// - One 10 us pulse every second
// - Pulse rising edge marks the UTC second
// - Two independently configurable serial ports
// - Port settings kept in non-volatile storage
// - Every packet carries one identification byte
// - Packets start and end with delimiters
// - Solutions and periodic reports unsolicited; other data only on request
// - Time, health, status every five seconds
// - Position every second in selected format
// - Velocity and satellite selection every second
// - Differential fix report in differential mode and at the boot epoch
// - Periodic reports start without host input
// - Navigation solution once per whole second
// - Pulse steered in internal clock steps
// - Power-up sequence ends with differential fix
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.svh"

module gpr_sched
    import gpr_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `GPR_CLK_HZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Timing control from navigation logic
    input wire logic utc_align,
    input wire logic steer_early,
    input wire logic steer_late,
    input wire logic differential_correction_mode,
    input wire gpr_fmt_s fmt,
    output logic second_timing_pulse,
    output logic nav_solve,
    // Host request for an on-demand report
    input wire logic host_req_valid,
    input wire logic [7:0] host_req_id,
    output logic host_req_ready,
    output logic cmd_ready,
    // Payload source for the packet being framed
    output logic [7:0] report_id,
    output logic report_start,
    input wire logic payload_valid,
    input wire logic [7:0] payload_data,
    input wire logic payload_last,
    output logic payload_ready,
    // Byte stream to the control serial port
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Port configuration and non-volatile store
    input wire gpr_port_cfg_s nv_cfg,
    input wire logic cfg_wr_valid,
    input wire gpr_port_cfg_s cfg_wr_data,
    output gpr_port_cfg_s port_cfg,
    output logic nv_store
);
    localparam int unsigned CW = $clog2(SEC_CYCLES + 1);
    localparam int unsigned PULSE = `GPR_PULSE_CYC;
    localparam int unsigned STEP = `GPR_STEER_CYC;
    localparam logic [CW-1:0] LAST = CW'(SEC_CYCLES - 1);
    localparam logic [CW-1:0] STEP_W = CW'(STEP);

    logic [CW-1:0] sec_q, sec_d;
    logic [9:0] wid_q;
    logic pulse_q, nav_q;
    logic [2:0] slow_q;
    logic boot_q, ready_q, hrdy_q;
    logic [`GPR_NPEND-1:0] pend_q, pend_d, set_v, clr_v;
    logic [7:0] host_id_q, id_q;
    logic [2:0] cur_q;
    gpr_fsm_e st_q, st_d;
    logic txv_q, txv_d, prdy_q, last_q, start_q, loaded_q, nvs_q;
    logic [7:0] txd_q, txd_d;
    gpr_port_cfg_s cfg_q;

    // Epoch and steering; a steer step never pushes the count past the wrap
    wire epoch = utc_align || (sec_q == LAST);
    wire can_late = sec_q >= STEP_W;
    wire can_early = sec_q < (LAST - STEP_W);
    always_comb begin
        sec_d = sec_q + CW'(1);
        if (epoch) begin
            sec_d = '0;
        end else if (steer_early && can_early) begin
            sec_d = sec_q + STEP_W + CW'(1);
        end else if (steer_late && can_late) begin
            sec_d = sec_q - STEP_W + CW'(1);
        end
    end

    wire slow_due = epoch && (slow_q == 3'(`GPR_SLOW_EPOCHS - 1));
    wire host_take = host_req_valid && hrdy_q;

    // Periodic requests all hang off the pulse epoch
    always_comb begin
        set_v = '0;
        set_v[`GPR_P_TIME] = slow_due || (epoch && boot_q);
        set_v[`GPR_P_HEALTH] = slow_due || (epoch && boot_q);
        set_v[`GPR_P_STATUS] = slow_due || (epoch && boot_q);
        set_v[`GPR_P_POS] = epoch;
        set_v[`GPR_P_VEL] = epoch;
        set_v[`GPR_P_SATSEL] = epoch;
        set_v[`GPR_P_DIFFFIX] = epoch && (differential_correction_mode
                                          || boot_q);
        set_v[`GPR_P_HOST] = host_take;
    end

    // Lowest pending bit is served first, so the power-up burst ends with
    // the differential fix report
    logic [2:0] pick;
    logic any_pend;
    always_comb begin
        pick = 3'h0;
        any_pend = 1'b0;
        for (int i = `GPR_NPEND - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick = 3'(i);
                any_pend = 1'b1;
            end
        end
    end

    wire [7:0] pos_id = (fmt.pos_fmt == 2'h0) ? `GPR_ID_POS_XYZ_S :
                        (fmt.pos_fmt == 2'h1) ? `GPR_ID_POS_XYZ_D :
                        (fmt.pos_fmt == 2'h2) ? `GPR_ID_POS_LLA_S :
                        `GPR_ID_POS_LLA_D;
    wire [7:0] vel_id = fmt.vel_enu ? `GPR_ID_VEL_ENU : `GPR_ID_VEL_XYZ;
    wire [7:0] pick_id = (pick == 3'(`GPR_P_TIME)) ? `GPR_ID_TIME :
                         (pick == 3'(`GPR_P_HEALTH)) ? `GPR_ID_HEALTH :
                         (pick == 3'(`GPR_P_STATUS)) ? `GPR_ID_STATUS :
                         (pick == 3'(`GPR_P_POS)) ? pos_id :
                         (pick == 3'(`GPR_P_VEL)) ? vel_id :
                         (pick == 3'(`GPR_P_SATSEL)) ? `GPR_ID_SATSEL :
                         (pick == 3'(`GPR_P_DIFFFIX)) ? `GPR_ID_DIFFFIX :
                         host_id_q;

    // Framer: framing bytes load while the output slot is empty or draining,
    // payload bytes only while it is empty, trading throughput for a single-register stream
    wire slot_free = !txv_q || tx_ready;
    wire take_pay = prdy_q && payload_valid;
    wire begin_pkt = (st_q == GPR_IDLE) && slot_free && any_pend;
    wire pkt_done = (st_q == GPR_TAIL2) && slot_free;
    always_comb begin
        st_d = st_q;
        txd_d = txd_q;
        txv_d = txv_q && !tx_ready;
        clr_v = '0;
        unique case (st_q)
            GPR_IDLE: if (begin_pkt) begin
                txd_d = `GPR_DLE;
                txv_d = 1'b1;
                clr_v[pick] = 1'b1;
                st_d = GPR_ID;
            end
            GPR_ID: if (slot_free) begin
                txd_d = id_q;
                txv_d = 1'b1;
                st_d = (id_q == `GPR_DLE) ? GPR_ESC : GPR_BODY;
            end
            GPR_BODY: if (take_pay) begin
                txd_d = payload_data;
                txv_d = 1'b1;
                st_d = (payload_data == `GPR_DLE) ? GPR_ESC :
                       payload_last ? GPR_TAIL1 : GPR_BODY;
            end
            GPR_ESC: if (slot_free) begin
                txd_d = `GPR_DLE;
                txv_d = 1'b1;
                st_d = last_q ? GPR_TAIL1 : GPR_BODY;
            end
            GPR_TAIL1: if (slot_free) begin
                txd_d = `GPR_DLE;
                txv_d = 1'b1;
                st_d = GPR_TAIL2;
            end
            GPR_TAIL2: if (slot_free) begin
                txd_d = `GPR_ETX;
                txv_d = 1'b1;
                st_d = GPR_IDLE;
            end
            default: st_d = GPR_IDLE;
        endcase
    end

    // Set wins over clear for a report that falls due as it starts
    assign pend_d = (pend_q & ~clr_v) | set_v;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec_q <= '0;
            wid_q <= '0;
            pulse_q <= 1'b0;
            nav_q <= 1'b0;
            slow_q <= '0;
        end else begin
            sec_q <= sec_d;
            nav_q <= epoch;
            if (epoch) begin
                // Boot epoch sends the slow group, so it restarts the count
                slow_q <= (slow_due || boot_q) ? 3'h0 : slow_q + 3'h1;
            end
            if (epoch) begin
                pulse_q <= 1'b1;
                wid_q <= 10'h000;
            end else if (pulse_q) begin
                pulse_q <= (wid_q != 10'(PULSE - 1));
                wid_q <= wid_q + 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= '0;
            boot_q <= 1'b1;
            ready_q <= 1'b0;
            hrdy_q <= 1'b0;
            host_id_q <= 8'h00;
            id_q <= 8'h00;
            cur_q <= 3'h0;
        end else begin
            pend_q <= pend_d;
            if (epoch) begin
                boot_q <= 1'b0;
            end
            if (pkt_done && cur_q == 3'(`GPR_P_DIFFFIX)) begin
                ready_q <= 1'b1;
            end
            hrdy_q <= ready_q && !pend_d[`GPR_P_HOST] && !host_take;
            if (host_take) begin
                host_id_q <= host_req_id;
            end
            if (begin_pkt) begin
                id_q <= pick_id;
                cur_q <= pick;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= GPR_IDLE;
            txv_q <= 1'b0;
            txd_q <= 8'h00;
            prdy_q <= 1'b0;
            last_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            st_q <= st_d;
            txv_q <= txv_d;
            txd_q <= txd_d;
            prdy_q <= (st_d == GPR_BODY) && !txv_d;
            // A stale last flag would cut an escaped identifier's packet
            if (begin_pkt) begin
                last_q <= 1'b0;
            end else if (take_pay) begin
                last_q <= payload_last;
            end
            start_q <= begin_pkt;
        end
    end

    // Stored port settings load once after reset release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            loaded_q <= 1'b0;
            cfg_q <= '0;
            nvs_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
            nvs_q <= cfg_wr_valid;
            if (!loaded_q) begin
                cfg_q <= nv_cfg;
            end else if (cfg_wr_valid) begin
                cfg_q <= cfg_wr_data;
            end
        end
    end

    assign second_timing_pulse = pulse_q;
    assign nav_solve = nav_q;
    assign host_req_ready = hrdy_q;
    assign cmd_ready = ready_q;
    assign report_id = id_q;
    assign report_start = start_q;
    assign payload_ready = prdy_q;
    assign tx_valid = txv_q;
    assign tx_data = txd_q;
    assign port_cfg = cfg_q;
    assign nv_store = nvs_q;

    property p_pulse_rise;
        @(posedge ref_clk) disable iff (rst)
        epoch |=> second_timing_pulse && wid_q == 10'h000;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise)
        else $error("pulse did not start at epoch");

    property p_pulse_width;
        @(posedge ref_clk) disable iff (rst)
        $fell(second_timing_pulse) |-> $past(wid_q) == 10'(PULSE - 1)
            || $past(epoch);
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse width wrong");

    property p_nav;
        @(posedge ref_clk) disable iff (rst)
        $rose(second_timing_pulse) |-> nav_solve;
    endproperty
    a_nav: assert property (p_nav)
        else $error("solution not tied to pulse");

    property p_pos_sched;
        @(posedge ref_clk) disable iff (rst)
        epoch |=> pend_q[`GPR_P_POS] && pend_q[`GPR_P_SATSEL];
    endproperty
    a_pos_sched: assert property (p_pos_sched)
        else $error("position report not scheduled");

    property p_diff_off;
        @(posedge ref_clk) disable iff (rst)
        epoch && !differential_correction_mode && !boot_q
            && !pend_q[`GPR_P_DIFFFIX] |=> !pend_q[`GPR_P_DIFFFIX];
    endproperty
    a_diff_off: assert property (p_diff_off)
        else $error("fix mode report outside differential mode");

    sequence s_open;
        st_q == GPR_IDLE && begin_pkt;
    endsequence
    sequence s_lead;
        tx_valid && tx_data == `GPR_DLE;
    endsequence
    property p_frame;
        @(posedge ref_clk) disable iff (rst)
        s_open |=> s_lead;
    endproperty
    a_frame: assert property (p_frame)
        else $error("packet not opened by delimiter");

    property p_escape;
        @(posedge ref_clk) disable iff (rst)
        take_pay && payload_data == `GPR_DLE |=> st_q == GPR_ESC;
    endproperty
    a_escape: assert property (p_escape)
        else $error("delimiter data byte not escaped");

    property p_host_gate;
        @(posedge ref_clk) disable iff (rst)
        !cmd_ready |-> !host_req_ready;
    endproperty
    a_host_gate: assert property (p_host_gate)
        else $error("host request taken before ready");
endmodule : gpr_sched

`default_nettype wire

// ---- tb/gpr_host_model.sv ----
// Far-side model: payload source and control port byte sink that deframes.
// Assumes one ref_clk; stall makes tx_ready alternate to slow the sink.
`timescale 1ns/1ps
`default_nettype none

module gpr_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    // Payload source
    input wire logic report_start,
    input wire logic payload_ready,
    output logic payload_valid,
    output logic [7:0] payload_data,
    output logic payload_last,
    // Byte sink
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] ids_q[$];
    int bad = 0;
    int st = 0;
    int nb = 0;
    int pi = 0;

    // Body holds a delimiter and a terminator value to exercise escaping
    function automatic logic [7:0] body(input int i);
        return i == 0 ? 8'h10 : i == 1 ? 8'h03 : 8'hA5;
    endfunction : body

    task automatic rx(input logic [7:0] b);
        case (st)
            0: if (b == 8'h10) st = 1; else bad++;
            1: if (b == 8'h10) st = 2; else begin
                ids_q.push_back(b);
                st = 3;
                nb = 0;
            end
            2: begin
                if (b != 8'h10) bad++;
                ids_q.push_back(8'h10);
                st = 3;
                nb = 0;
            end
            3: if (b == 8'h10) st = 4; else begin
                if (b != body(nb)) bad++;
                nb++;
            end
            default: if (b == 8'h10) begin
                if (body(nb) != 8'h10) bad++;
                nb++;
                st = 3;
            end else begin
                if (b != 8'h03 || nb != 3) bad++;
                st = 0;
            end
        endcase
    endtask : rx

    always @(posedge ref_clk) begin
        if (rst) begin
            tx_ready <= 1'b0;
            payload_valid <= 1'b0;
            payload_last <= 1'b0;
            payload_data <= 8'h00;
            st = 0;
        end else begin
            tx_ready <= stall ? ~tx_ready : 1'b1;
            if (report_start) begin
                pi = 0;
                payload_valid <= 1'b1;
                payload_data <= body(0);
                payload_last <= 1'b0;
            end else if (payload_valid && payload_ready) begin
                if (pi == 2) begin
                    payload_valid <= 1'b0;
                    payload_data <= ~payload_data;
                end else begin
                    pi++;
                    payload_data <= body(pi);
                    payload_last <= (pi == 2);
                end
            end else if (!payload_valid) begin
                // Released data never holds the last value
                payload_data <= ~payload_data;
            end
            if (tx_valid && tx_ready) rx(tx_data);
        end
    end
endmodule : gpr_host_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the pulse and report scheduler.
// Assumes a shortened second of SEC cycles and the host model beside it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_top;
    import gpr_pkg::*;
    localparam int unsigned SEC = 1000;
    logic ref_clk = 0, rst = 1, utc_align = 0, steer_early = 0;
    logic steer_late = 0, diff = 0, host_req_valid = 0, cfg_wr_valid = 0;
    logic stall = 0;
    logic [7:0] host_req_id = 8'h00;
    gpr_fmt_s fmt = '0;
    gpr_port_cfg_s nv_cfg = 16'h5AC3, cfg_wr_data = '0, port_cfg;
    logic second_timing_pulse, nav_solve, host_req_ready, cmd_ready;
    logic report_start, payload_valid, payload_last, payload_ready;
    logic tx_valid, tx_ready, nv_store;
    logic [7:0] payload_data, tx_data, report_id;
    int err_total = 0, samples_checked = 0, cyc = 0, n;

    always #10 ref_clk = ~ref_clk;

    gpr_sched #(.SEC_CYCLES(SEC)) DUT (.ref_clk, .rst, .utc_align,
        .steer_early, .steer_late, .differential_correction_mode(diff),
        .fmt, .second_timing_pulse, .nav_solve, .host_req_valid,
        .host_req_id, .host_req_ready, .cmd_ready, .report_id,
        .report_start, .payload_valid, .payload_data, .payload_last,
        .payload_ready, .tx_valid, .tx_data, .tx_ready, .nv_cfg,
        .cfg_wr_valid, .cfg_wr_data, .port_cfg, .nv_store);
    gpr_host_model u_host (.ref_clk, .rst, .stall, .report_start,
        .payload_ready, .payload_valid, .payload_data, .payload_last,
        .tx_valid, .tx_data, .tx_ready);

    task automatic wrap_up;
        $display("err_total=%0d samples_checked=%0d", err_total,
            samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // Whole run is about 14000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    // Counts samples until the next rising edge of the pulse
    task automatic wait_rise(output int c);
        c = 0;
        while (second_timing_pulse === 1'b1 && c < 2000) begin tick(); c++; end
        while (second_timing_pulse !== 1'b1 && c < 3000) begin tick(); c++; end
    endtask : wait_rise

    task automatic chk_q(input logic [7:0] e[$]);
        `CHK("frames", e.size(), u_host.ids_q.size())
        foreach (e[i]) `CHK("id", e[i], u_host.ids_q[i])
        u_host.ids_q.delete();
    endtask : chk_q

    task automatic t_config;
        repeat (2) tick();
        `CHK("port_cfg", nv_cfg, port_cfg)
        `CHK("req_ready", 1'b0, host_req_ready)
        @(posedge ref_clk);
        cfg_wr_valid <= 1'b1;
        cfg_wr_data <= 16'hC35A;
        @(posedge ref_clk);
        cfg_wr_valid <= 1'b0;
        #1;
        `CHK("port_cfg_wr", 16'hC35A, port_cfg)
        `CHK("nv_store", 1'b1, nv_store)
        tick();
        `CHK("nv_store_end", 1'b0, nv_store)
    endtask : t_config

    task automatic t_boot;
        @(posedge ref_clk) stall <= 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 3000) begin tick(); n++; end
        `CHK("cmd_ready", 1'b1, cmd_ready)
        chk_q('{8'h41, 8'h46, 8'h4B, 8'h42, 8'h43, 8'h6D, 8'h82});
    endtask : t_boot

    task automatic t_sched;
        logic [7:0] pos_t[4];
        logic [7:0] e[$];
        int times;
        int w;
        pos_t = '{8'h42, 8'h83, 8'h4A, 8'h84};
        times = 0;
        wait_rise(n);
        for (int k = 1; k <= 5; k++) begin
            `CHK("nav_solve", 1'b1, nav_solve)
            w = 0;
            while (second_timing_pulse === 1'b1 && w < 600) begin
                tick();
                w++;
            end
            `CHK("width", 500, w)
            repeat (400) tick();
            foreach (u_host.ids_q[i]) if (u_host.ids_q[i] == 8'h41) times++;
            e.delete();
            // Epoch k+1; boot epoch sent the slow group, next is 5 s later
            if (k == 5) e = '{8'h41, 8'h46, 8'h4B};
            e.push_back(pos_t[fmt.pos_fmt]);
            e.push_back(fmt.vel_enu ? 8'h56 : 8'h43);
            e.push_back(8'h6D);
            if (diff) e.push_back(8'h82);
            chk_q(e);
            @(posedge ref_clk);
            fmt <= gpr_fmt_s'({k[1:0], k[0]});
            diff <= k[0];
            stall <= k[0];
            wait_rise(n);
            `CHK("period", SEC, w + 401 + n)
        end
        `CHK("time_reports", 1, times)
    endtask : t_sched

    task automatic t_steer;
        for (int j = 0; j < 2; j++) begin
            wait_rise(n);
            repeat (100) @(posedge ref_clk);
            steer_early <= (j == 0);
            steer_late <= (j == 1);
            @(posedge ref_clk);
            steer_early <= 1'b0;
            steer_late <= 1'b0;
            #1;
            wait_rise(n);
            `CHK("steer", j == 0 ? SEC - 15 : SEC + 15, n + 101)
        end
    endtask : t_steer

    task automatic t_align;
        wait_rise(n);
        repeat (600) @(posedge ref_clk);
        utc_align <= 1'b1;
        @(posedge ref_clk);
        utc_align <= 1'b0;
        #1;
        `CHK("align", 1'b1, second_timing_pulse)
        wait_rise(n);
        `CHK("period_after_align", SEC, n)
    endtask : t_align

    task automatic t_host;
        repeat (200) tick();
        u_host.ids_q.delete();
        @(posedge ref_clk);
        host_req_valid <= 1'b1;
        host_req_id <= 8'h10;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (host_req_ready !== 1'b1 && n < 100);
        host_req_valid <= 1'b0;
        n = 0;
        while (report_start !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        `CHK("report_id", 8'h10, report_id)
        repeat (100) tick();
        chk_q('{8'h10});
    endtask : t_host

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_config();
        t_boot();
        t_sched();
        t_steer();
        t_align();
        t_host();
        `CHK("bad_frames", 0, u_host.bad)
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
